// ==== verilog/fpwm_top.sv ====
// Contract
// - Config bit 6 at 0x40 picks high frequency when 0 (reset), low when 1.
// - All four outputs share one drive frequency from the mode bit and field.
// - High frequency: field 000 gives 1.4 kHz, any other code 22.5 kHz.
// - Low frequency: codes 000..111 give 11 to 88.2 Hz in listed steps.
// - A set inversion bit complements that channel's waveform and duty.
// - Register 0x68 bit 5 inverts channel a, bit 4 channel b; reset 0.
// - Register 0x69 bit 5 inverts channel c, bit 4 channel d; reset 0.
// - With full-speed enabled, pin driven low demands maximum duty on all fans.
// - During full speed every output holds a constant logic high.
// - Low frequency mode stretches short pulses; high frequency mode does not.
`timescale 1ns/1ps
`include "fpwm_map.svh"

module fpwm_top #(
  parameter int CNT_W = 24,
  parameter int HF_SLOW_CYC = `FPWM_PERIOD_CYC(`FPWM_FREQ_HF_SLOW_DHZ),
  // Slow drive periods, code 7 first
  parameter logic [7:0][31:0] LF_CYC_TAB =
  {
    32'(`FPWM_PERIOD_CYC(`FPWM_FREQ_LF7_DHZ)),
    32'(`FPWM_PERIOD_CYC(`FPWM_FREQ_LF6_DHZ)),
    32'(`FPWM_PERIOD_CYC(`FPWM_FREQ_LF5_DHZ)),
    32'(`FPWM_PERIOD_CYC(`FPWM_FREQ_LF4_DHZ)),
    32'(`FPWM_PERIOD_CYC(`FPWM_FREQ_LF3_DHZ)),
    32'(`FPWM_PERIOD_CYC(`FPWM_FREQ_LF2_DHZ)),
    32'(`FPWM_PERIOD_CYC(`FPWM_FREQ_LF1_DHZ)),
    32'(`FPWM_PERIOD_CYC(`FPWM_FREQ_LF0_DHZ))
  }
)(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata_q,
  // Per-channel duty from the host side
  input wire logic [7:0] duty_a,
  input wire logic [7:0] duty_b,
  input wire logic [7:0] duty_c,
  input wire logic [7:0] duty_d,
  // Full-speed pin
  input wire logic full_speed_en,
  input wire logic full_speed_n,
  // Fan drive outputs
  output logic fan_drive_out_a,
  output logic fan_drive_out_b,
  output logic fan_drive_out_c,
  output logic fan_drive_out_d
);

  localparam int NCH = 4;
  localparam int HF_FAST_CYC = `FPWM_PERIOD_CYC(`FPWM_FREQ_HF_FAST_DHZ);
  localparam logic [7:0][CNT_W-1:0] LF_CYC =
  {
    CNT_W'(LF_CYC_TAB[7]), CNT_W'(LF_CYC_TAB[6]), CNT_W'(LF_CYC_TAB[5]), CNT_W'(LF_CYC_TAB[4]),
    CNT_W'(LF_CYC_TAB[3]), CNT_W'(LF_CYC_TAB[2]), CNT_W'(LF_CYC_TAB[1]), CNT_W'(LF_CYC_TAB[0])
  };

  // ========================================================
  // Elaboration checks
  if (CNT_W < 2 || CNT_W > 31)
  begin : g_bad_width
    $error("fpwm_top: CNT_W out of range");
  end

  if (HF_SLOW_CYC < 2)
  begin : g_slow_short
    $error("fpwm_top: slow high frequency period too short");
  end

  if (HF_SLOW_CYC >= (64'h1 << CNT_W))
  begin : g_slow_wide
    $error("fpwm_top: slow high frequency period does not fit CNT_W");
  end

  // The fast rate is fixed, so a narrow counter can still miss it
  if (HF_FAST_CYC >= (64'h1 << CNT_W))
  begin : g_fast_wide
    $error("fpwm_top: fast high frequency period does not fit CNT_W");
  end

  for (genvar k = 0; k < 8; k++)
  begin : g_lf_chk
    if (LF_CYC_TAB[k] < 32'h2)
    begin : g_short
      $error("fpwm_top: low frequency period too short");
    end

    if (LF_CYC_TAB[k] >= (64'h1 << CNT_W))
    begin : g_wide
      $error("fpwm_top: low frequency period does not fit CNT_W");
    end
  end

  // ========================================================
  // Register file
  fpwm_pkg::fpwm_byte_t cfg1_q;
  fpwm_pkg::fpwm_byte_t cfg2_q;
  fpwm_pkg::fpwm_byte_t pair_a_q;
  fpwm_pkg::fpwm_byte_t pair_b_q;
  fpwm_pkg::fpwm_byte_t rdata_d;
  fpwm_pkg::fpwm_byte_t status;

  // Every bit stored; only the listed fields steer the drive
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cfg1_q <= `FPWM_REG_RST;
    end
    else if (reg_wr && reg_addr == `FPWM_ADDR_CFG1)
    begin
      cfg1_q <= reg_wdata;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cfg2_q <= `FPWM_REG_RST;
    end
    else if (reg_wr && reg_addr == `FPWM_ADDR_CFG2)
    begin
      cfg2_q <= reg_wdata;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pair_a_q <= `FPWM_REG_RST;
    end
    else if (reg_wr && reg_addr == `FPWM_ADDR_PAIR_A)
    begin
      pair_a_q <= reg_wdata;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pair_b_q <= `FPWM_REG_RST;
    end
    else if (reg_wr && reg_addr == `FPWM_ADDR_PAIR_B)
    begin
      pair_b_q <= reg_wdata;
    end
  end

  // ========================================================
  // Live controls
  fpwm_pkg::fpwm_mode_t mode_req;
  fpwm_pkg::fpwm_freq_t freq_req;
  logic [NCH-1:0] inv_req;
  logic full_speed;

  assign mode_req = fpwm_pkg::fpwm_mode_t'(cfg1_q[`FPWM_CFG1_LF_BIT]);
  assign freq_req = cfg2_q[`FPWM_CFG2_FREQ_MSB:`FPWM_CFG2_FREQ_LSB];
  assign inv_req = {pair_b_q[`FPWM_INV_LO_BIT], pair_b_q[`FPWM_INV_HI_BIT],
                    pair_a_q[`FPWM_INV_LO_BIT], pair_a_q[`FPWM_INV_HI_BIT]};
  // Pin only counts when configured for the full-speed function
  assign full_speed = full_speed_en & ~full_speed_n;

  // ========================================================
  // Timebase and comparators
  fpwm_tb_if #(.CNT_W(CNT_W)) tb_if ();
  logic [NCH-1:0] wave;
  fpwm_pkg::fpwm_duty_t [NCH-1:0] duty;

  assign duty = {duty_d, duty_c, duty_b, duty_a};

  fpwm_timebase #(
    .CNT_W(CNT_W),
    .HF_SLOW_CYC(CNT_W'(HF_SLOW_CYC)),
    .HF_FAST_CYC(CNT_W'(HF_FAST_CYC)),
    .LF_CYC(LF_CYC)
  ) u_timebase (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .mode_req(mode_req),
    .freq_req(freq_req),
    .tb(tb_if.src)
  );

  fpwm_chan #(
    .CNT_W(CNT_W),
    .NCH(NCH)
  ) u_chan (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .tb(tb_if.snk),
    .duty(duty),
    .wave_q(wave)
  );

  // ========================================================
  // Inversion shadow, aligned with the registered waveform
  logic [NCH-1:0] inv_q;

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      inv_q <= '0;
    end
    else if (tb_if.start)
    begin
      inv_q <= inv_req;
    end
  end

  // ========================================================
  // Output stage
  logic [NCH-1:0] drive_d;
  logic [NCH-1:0] drive_q;

  always_comb
  begin
    if (full_speed)
    begin
      // Overrides inversion too; fans must never stop here
      drive_d = '1;
    end
    else
    begin
      drive_d = wave ^ inv_q;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      drive_q <= '0;
    end
    else
    begin
      drive_q <= drive_d;
    end
  end

  assign fan_drive_out_a = drive_q[0];
  assign fan_drive_out_b = drive_q[1];
  assign fan_drive_out_c = drive_q[2];
  assign fan_drive_out_d = drive_q[3];

  // ========================================================
  // Read path
  // Status is read-only; a write to it is ignored like an unmapped one
  assign status = {full_speed, tb_if.mode == fpwm_pkg::fpwm_mode_lf, 2'h0, drive_q};

  always_comb
  begin
    case (reg_addr)
      `FPWM_ADDR_CFG1:
      begin
        rdata_d = cfg1_q;
      end
      `FPWM_ADDR_CFG2:
      begin
        rdata_d = cfg2_q;
      end
      `FPWM_ADDR_PAIR_A:
      begin
        rdata_d = pair_a_q;
      end
      `FPWM_ADDR_PAIR_B:
      begin
        rdata_d = pair_b_q;
      end
      `FPWM_ADDR_STATUS:
      begin
        rdata_d = status;
      end
      default:
      begin
        rdata_d = 8'h00;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      reg_rdata_q <= 8'h00;
    end
    else
    begin
      reg_rdata_q <= rdata_d;
    end
  end

endmodule : fpwm_top

// ==== verilog/fpwm_map.svh ====
`ifndef FPWM_MAP_SVH
`define FPWM_MAP_SVH

// ==========================================================
// Core clock
`define FPWM_CLK_HZ 10000000

// ==========================================================
// Drive frequencies in units of 0.1 Hz
`define FPWM_FREQ_HF_SLOW_DHZ 14000
`define FPWM_FREQ_HF_FAST_DHZ 225000
`define FPWM_FREQ_LF0_DHZ 110
`define FPWM_FREQ_LF1_DHZ 147
`define FPWM_FREQ_LF2_DHZ 221
`define FPWM_FREQ_LF3_DHZ 294
`define FPWM_FREQ_LF4_DHZ 353
`define FPWM_FREQ_LF5_DHZ 441
`define FPWM_FREQ_LF6_DHZ 588
`define FPWM_FREQ_LF7_DHZ 882

// Period in core clock cycles for a frequency in 0.1 Hz
`define FPWM_PERIOD_CYC(f) ((`FPWM_CLK_HZ * 10) / (f))

// ==========================================================
// Register offsets
`define FPWM_ADDR_CFG1 8'h40
`define FPWM_ADDR_CFG2 8'h74
`define FPWM_ADDR_PAIR_A 8'h68
`define FPWM_ADDR_PAIR_B 8'h69
`define FPWM_ADDR_STATUS 8'h7E

// ==========================================================
// Field positions and reset values
`define FPWM_CFG1_LF_BIT 6
`define FPWM_CFG2_FREQ_MSB 6
`define FPWM_CFG2_FREQ_LSB 4
`define FPWM_INV_HI_BIT 5
`define FPWM_INV_LO_BIT 4
`define FPWM_REG_RST 8'h00
`define FPWM_FREQ_SLOW_CODE 3'h0
`define FPWM_DUTY_FULL 8'hFF
`define FPWM_STRETCH_SHIFT 4

`endif

// ==== verilog/fpwm_pkg.sv ====
package fpwm_pkg;

  // ========================================================
  // Types
  typedef enum logic
  {
    fpwm_mode_hf = 1'b0,
    fpwm_mode_lf = 1'b1
  } fpwm_mode_t;

  typedef logic [2:0] fpwm_freq_t;
  typedef logic [7:0] fpwm_duty_t;
  typedef logic [7:0] fpwm_byte_t;

endpackage : fpwm_pkg

// ==== verilog/fpwm_tb_if.sv ====
`timescale 1ns/1ps

// ==========================================================
// Shared PWM timebase towards the channel comparators
interface fpwm_tb_if #(
  parameter int CNT_W = 24
);
  logic start;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] period;
  fpwm_pkg::fpwm_mode_t mode;

  modport src (output start, output cnt, output period, output mode);
  modport snk (input start, input cnt, input period, input mode);
endinterface : fpwm_tb_if

// ==== verilog/fpwm_timebase.sv ====
`timescale 1ns/1ps
`include "fpwm_map.svh"

module fpwm_timebase #(
  parameter int CNT_W = 24,
  parameter logic [CNT_W-1:0] HF_SLOW_CYC = CNT_W'(`FPWM_PERIOD_CYC(`FPWM_FREQ_HF_SLOW_DHZ)),
  parameter logic [CNT_W-1:0] HF_FAST_CYC = CNT_W'(`FPWM_PERIOD_CYC(`FPWM_FREQ_HF_FAST_DHZ)),
  parameter logic [7:0][CNT_W-1:0] LF_CYC = '0
)(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Live configuration
  input wire fpwm_pkg::fpwm_mode_t mode_req,
  input wire fpwm_pkg::fpwm_freq_t freq_req,
  // Timebase out
  fpwm_tb_if.src tb
);

  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] period_q;
  logic [CNT_W-1:0] period_d;
  fpwm_pkg::fpwm_mode_t mode_q;

  // ========================================================
  // Period lookup
  always_comb
  begin
    if (mode_req == fpwm_pkg::fpwm_mode_lf)
    begin
      period_d = LF_CYC[freq_req];
    end
    else if (freq_req == `FPWM_FREQ_SLOW_CODE)
    begin
      period_d = HF_SLOW_CYC;
    end
    else
    begin
      period_d = HF_FAST_CYC;
    end
  end

  // ========================================================
  // Counter; settings taken only on wrap so no pulse is cut short
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_q <= '0;
      period_q <= HF_FAST_CYC;
      mode_q <= fpwm_pkg::fpwm_mode_hf;
    end
    else if (cnt_q >= period_q - CNT_W'(1))
    begin
      cnt_q <= '0;
      period_q <= period_d;
      mode_q <= mode_req;
    end
    else
    begin
      cnt_q <= cnt_q + CNT_W'(1);
    end
  end

  // One counter for all channels
  assign tb.start = (cnt_q == '0);
  assign tb.cnt = cnt_q;
  assign tb.period = period_q;
  assign tb.mode = mode_q;

endmodule : fpwm_timebase

// ==== verilog/fpwm_chan.sv ====
`timescale 1ns/1ps
`include "fpwm_map.svh"

module fpwm_chan #(
  parameter int CNT_W = 24,
  parameter int NCH = 4
)(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Timebase and duty
  fpwm_tb_if.snk tb,
  input wire fpwm_pkg::fpwm_duty_t [NCH-1:0] duty,
  // Raw waveform
  output logic [NCH-1:0] wave_q
);

  for (genvar i = 0; i < NCH; i++)
  begin : g_ch
    logic [CNT_W-1:0] thr_q;
    logic [CNT_W-1:0] thr_new;
    logic [CNT_W-1:0] thr_min;
    logic [CNT_W+7:0] prod;

    always_comb
    begin
      prod = duty[i] * tb.period;
      thr_min = tb.period >> `FPWM_STRETCH_SHIFT;
      if (duty[i] == `FPWM_DUTY_FULL)
      begin
        thr_new = tb.period;
      end
      else
      begin
        thr_new = prod[CNT_W+7:8];
      end
      // Short pulses starve the tach reading at low rates
      if (tb.mode == fpwm_pkg::fpwm_mode_lf && duty[i] != '0 && thr_new < thr_min)
      begin
        thr_new = thr_min;
      end
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
      if (!rst_n)
      begin
        thr_q <= '0;
      end
      else if (tb.start)
      begin
        thr_q <= thr_new;
      end
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
      if (!rst_n)
      begin
        wave_q[i] <= 1'b0;
      end
      else
      begin
        wave_q[i] <= tb.cnt < (tb.start ? thr_new : thr_q);
      end
    end
  end

endmodule : fpwm_chan

// ==== dv/fpwm_top_props.sv ====
`timescale 1ns/1ps
// ==========
// Port checker
module fpwm_top_props (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata_q,
  // Duty and full speed
  input wire logic [7:0] duty_a,
  input wire logic [7:0] duty_b,
  input wire logic [7:0] duty_c,
  input wire logic [7:0] duty_d,
  input wire logic full_speed_en,
  input wire logic full_speed_n,
  // Fan drive
  input wire logic fan_drive_out_a,
  input wire logic fan_drive_out_b,
  input wire logic fan_drive_out_c,
  input wire logic fan_drive_out_d
);
  logic [7:0] cfg1_q, cfg2_q, pa_q, pb_q, exp_q;
  logic ok_q, fs, calm;
  logic [9:0] calm_q;
  logic [31:0] duty_q;
  assign fs = full_speed_en && !full_speed_n;
  // Over two of the longest periods, so settings taken at a wrap have landed
  assign calm = calm_q == 10'h3FF;
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      {cfg1_q, cfg2_q, pa_q, pb_q, exp_q} <= 40'h0;
      ok_q <= 1'b0;
    end
    else
    begin
      ok_q <= reg_addr != 8'h7E;
      case (reg_addr)
        8'h40: exp_q <= cfg1_q;
        8'h74: exp_q <= cfg2_q;
        8'h68: exp_q <= pa_q;
        8'h69: exp_q <= pb_q;
        default: exp_q <= 8'h00;
      endcase
      if (reg_wr && reg_addr == 8'h40) cfg1_q <= reg_wdata;
      if (reg_wr && reg_addr == 8'h74) cfg2_q <= reg_wdata;
      if (reg_wr && reg_addr == 8'h68) pa_q <= reg_wdata;
      if (reg_wr && reg_addr == 8'h69) pb_q <= reg_wdata;
    end
  end
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      calm_q <= 10'h000;
      duty_q <= 32'h0;
    end
    else
    begin
      duty_q <= {duty_a, duty_b, duty_c, duty_d};
      if (reg_wr || fs || duty_q != {duty_a, duty_b, duty_c, duty_d})
        calm_q <= 10'h000;
      else if (!calm)
        calm_q <= calm_q + 10'h001;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  a_read_back: assert property (ok_q |-> reg_rdata_q == exp_q)
    else $error("read data differs from register model");
  a_full_speed_high: assert property (fs |=>
    {fan_drive_out_a, fan_drive_out_b, fan_drive_out_c, fan_drive_out_d} == 4'hF)
    else $error("full speed did not force outputs high");
  a_zero_duty_low: assert property (calm && duty_a == 8'h00 && !pa_q[5]
    |-> !fan_drive_out_a) else $error("zero duty output not low");
  a_full_duty_high: assert property (calm && duty_b == 8'hFF && !pa_q[4]
    |-> fan_drive_out_b) else $error("full duty output not high");
  a_inv_zero_high: assert property (calm && duty_c == 8'h00 && pb_q[5]
    |-> fan_drive_out_c) else $error("inverted zero duty not high");
  a_inv_full_low: assert property (calm && duty_d == 8'hFF && pb_q[4]
    |-> !fan_drive_out_d) else $error("inverted full duty not low");
  a_lf_min_pulse: assert property (calm && cfg1_q[6] && !pa_q[5] && duty_a != 8'h00
    && $rose(fan_drive_out_a) |=> fan_drive_out_a) else $error("short pulse in slow mode");
  a_common_wave: assert property (calm && duty_a == duty_b && pa_q[5] == pa_q[4]
    |-> fan_drive_out_a == fan_drive_out_b) else $error("channels a and b differ");
  cover property (fs);
  cover property (calm && cfg1_q[6] && $rose(fan_drive_out_a));
  cover property (ok_q && reg_addr == 8'h69 && reg_rdata_q != 8'h00);
endmodule : fpwm_top_props

bind fpwm_top fpwm_top_props u_props (.core_clk, .rst_n, .reg_addr, .reg_wr, .reg_wdata,
  .reg_rdata_q, .duty_a, .duty_b, .duty_c, .duty_d, .full_speed_en, .full_speed_n,
  .fan_drive_out_a, .fan_drive_out_b, .fan_drive_out_c, .fan_drive_out_d);

// ==== dv/fpwm_fan_model.sv ====
`timescale 1ns/1ps
// ==========
// Fan and alarm side
module fpwm_fan_model (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Sensed drive and alarm request
  input wire logic fan_drive_out_a,
  input wire logic alarm,
  // Alarm line and last full period
  output logic full_speed_n,
  output logic [15:0] per_q,
  output logic [15:0] hi_q
);
  logic [15:0] per_cnt_q, hi_cnt_q;
  logic prev_q;
  // Pulled up, pulled low only to demand cooling
  assign full_speed_n = alarm ? 1'b0 : 1'b1;
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      {per_cnt_q, hi_cnt_q, per_q, hi_q} <= 64'h0;
      prev_q <= 1'b0;
    end
    else
    begin
      prev_q <= fan_drive_out_a;
      if (fan_drive_out_a && !prev_q)
      begin
        per_q <= per_cnt_q + 16'h0001;
        hi_q <= hi_cnt_q;
        per_cnt_q <= 16'h0000;
        hi_cnt_q <= 16'h0001;
      end
      else
      begin
        per_cnt_q <= per_cnt_q + 16'h0001;
        hi_cnt_q <= hi_cnt_q + {15'h0000, fan_drive_out_a};
      end
    end
  end
endmodule : fpwm_fan_model

// ==== dv/four_channel_fan_pwm_drive_test.sv ====
`timescale 1ns/1ps
module four_channel_fan_pwm_drive_test;
  logic core_clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, full_speed_en = 1'b0, alarm = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata_q, d8;
  logic [7:0] duty_a = 8'h00, duty_b = 8'h00, duty_c = 8'h00, duty_d = 8'h00;
  logic full_speed_n, fan_drive_out_a, fan_drive_out_b, fan_drive_out_c, fan_drive_out_d;
  logic [15:0] per_q, hi_q;
  logic [7:0] addrs[5] = '{8'h40, 8'h74, 8'h68, 8'h69, 8'h12};
  integer seed = 32'h44c7095e;
  int n_mismatch = 0, comparisons = 0, cyc = 0, p;
  // ==========
  // Short periods keep the run brief
  fpwm_top #(.HF_SLOW_CYC(60), .LF_CYC_TAB({32'h28, 32'h3C, 32'h50, 32'h64, 32'h78, 32'hA0,
    32'hC8, 32'h12C})) uut (
    .core_clk, .rst_n, .reg_addr, .reg_wr, .reg_wdata, .reg_rdata_q, .duty_a, .duty_b,
    .duty_c, .duty_d, .full_speed_en, .full_speed_n, .fan_drive_out_a, .fan_drive_out_b,
    .fan_drive_out_c, .fan_drive_out_d);
  fpwm_fan_model fan (.core_clk, .rst_n, .fan_drive_out_a, .alarm, .full_speed_n, .per_q,
    .hi_q);
  initial forever #50 core_clk = ~core_clk;
  function automatic int period_of(logic lf, logic [2:0] code);
    int t[8] = '{300, 200, 160, 120, 100, 80, 60, 40};
    return lf ? t[code] : (code == 3'h0) ? 60 : 444;
  endfunction : period_of
  function automatic int high_of(logic lf, int per, logic [7:0] duty, logic inv);
    int thr;
    thr = (duty * per) >> 8;
    if (lf && thr < (per >> 4)) thr = per >> 4;
    return inv ? per - thr : thr;
  endfunction : high_of
  task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : chk
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(logic [7:0] a, logic [7:0] exp);
    @(posedge core_clk);
    reg_addr <= a;
    repeat (2) @(posedge core_clk);
    #1 chk("read data", 32'(reg_rdata_q), 32'(exp));
  endtask : rd
  task automatic meas(logic lf, logic [2:0] code, logic [7:0] duty, logic inv);
    p = period_of(lf, code);
    repeat (1100) @(posedge core_clk);
    #1 chk("period", 32'(per_q), 32'(p));
    chk("high time", 32'(hi_q), 32'(high_of(lf, p, duty, inv)));
  endtask : meas
  task automatic outs(logic [3:0] exp);
    #1 chk("outputs", 32'({fan_drive_out_d, fan_drive_out_c, fan_drive_out_b,
      fan_drive_out_a}), 32'(exp));
  endtask : outs
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : conclude
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      n_mismatch++;
      conclude();
    end
  end
  initial
  begin
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    foreach (addrs[i])
    begin
      rd(addrs[i], 8'h00);
      d8 = 8'($random(seed));
      wr(addrs[i], d8);
      rd(addrs[i], (i == 4) ? 8'h00 : d8);
    end
    wr(8'h68, 8'h00);
    wr(8'h69, 8'h00);
    for (int m = 0; m < 2; m++)
    begin
      for (int c = 0; c < 8; c++)
      begin
        d8 = 8'(32'h10 + $unsigned($random(seed)) % 224);
        wr(8'h40, 8'(m << 6));
        wr(8'h74, 8'(c << 4));
        {duty_a, duty_b, duty_c, duty_d} <= {4{d8}};
        meas(1'(m), 3'(c), d8, 1'b0);
      end
    end
    // Tiny duty in slow mode must still give a readable pulse
    @(posedge core_clk);
    duty_a <= 8'h01;
    meas(1'b1, 3'h7, 8'h01, 1'b0);
    wr(8'h40, 8'h00);
    wr(8'h74, 8'h00);
    wr(8'h68, 8'h20);
    duty_a <= 8'h40;
    meas(1'b0, 3'h0, 8'h40, 1'b1);
    wr(8'h68, 8'h00);
    wr(8'h69, 8'h30);
    {duty_a, duty_b, duty_c, duty_d} <= 32'h00FF00FF;
    repeat (1100) @(posedge core_clk);
    outs(4'h6);
    @(posedge core_clk);
    alarm <= 1'b1;
    repeat (5) @(posedge core_clk);
    outs(4'h6);
    @(posedge core_clk);
    full_speed_en <= 1'b1;
    repeat (2) @(posedge core_clk);
    outs(4'hF);
    rd(8'h7E, 8'h8F);
    @(posedge core_clk);
    alarm <= 1'b0;
    repeat (1100) @(posedge core_clk);
    outs(4'h6);
    conclude();
  end
endmodule : four_channel_fan_pwm_drive_test
